/* File: hw/cbdiag_params.svh */
`ifndef CBDIAG_PARAMS_SVH
`define CBDIAG_PARAMS_SVH

// Configuration offsets, byte addressed within each socket function.
`define CBDIAG_OFS_ID_BASE 8'h00
`define CBDIAG_OFS_ID_LAST 8'h03
`define CBDIAG_OFS_DEV_CTRL 8'h92
`define CBDIAG_OFS_DIAGNOSTIC_FIELD 8'h93

// Reset values applied by the global reset only.
`define CBDIAG_DEV_CTRL_RST 8'h66
`define CBDIAG_DIAGNOSTIC_FIELD_RST 8'h61

// Bits shared by both functions, and bits kept once per function.
`define CBDIAG_DEV_GLOBAL_MASK 8'h4F
`define CBDIAG_DEV_LOCAL_MASK 8'hA0
`define CBDIAG_DIAGNOSTIC_FIELD_GLOBAL_MASK 8'h9F
`define CBDIAG_DIAGNOSTIC_FIELD_LOCAL_MASK 8'h60

// Field positions of device control.
`define CBDIAG_DEV_PWR_LOCK_BIT 7
`define CBDIAG_DEV_ZERO_BIT 4
// Field positions of the diagnostic byte.
`define CBDIAG_DIAGNOSTIC_FIELD_ID_MASK_BIT 7

// Retry latency limits, in clocks.
`define CBDIAG_RETRY_LIMIT_BASE 7'd16
`define CBDIAG_RETRY_LIMIT_EXT 7'd64

// Discard timer lengths as powers of two, in clocks.
`define CBDIAG_DISCARD_LOG2_SHORT 10
`define CBDIAG_DISCARD_LOG2_LONG 15

`define CBDIAG_ID_ALL_ONES 8'hFF
`define CBDIAG_RDATA_NONE 8'h00
`define CBDIAG_NUM_FUNC 2

`endif

/* File: hw/cbdiag_pkg.sv */
package cbdiag_pkg;

  typedef enum logic [1:0] {
    CBDIAG_IRQ_PAR_PCI_ONLY = 2'b00,
    CBDIAG_IRQ_PAR_IRQ_PAR_PCI = 2'b01,
    CBDIAG_IRQ_SER_IRQ_PAR_PCI = 2'b10,
    CBDIAG_IRQ_SER_IRQ_SER_PCI = 2'b11
  } cbdiag_irq_mode_t;

  typedef struct packed {
    logic pwr_lock;
    logic three_volt_capable_force;
    logic legacy_diagnostic_field_bit;
    logic rsvd_zero;
    logic test_shorten;
    cbdiag_irq_mode_t irq_signal_mode;
    logic nand_tree_en;
  } cbdiag_dev_ctrl_t;

  typedef struct packed {
    logic id_mask;
    logic rsvd_rw;
    logic csc_route_sel;
    logic delayed_txn_disable;
    logic retry_latency_extend;
    logic card_discard_timer_sel;
    logic host_discard_timer_sel;
    logic async_status_change_irq;
  } cbdiag_diagnostic_field_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic func;
    logic [7:0] offset;
    logic [7:0] wdata;
  } cbdiag_cfg_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } cbdiag_cfg_rsp_t;

endpackage

/* File: hw/cbdiag_sync.sv */
`timescale 1ns/1ps

// Three-stage input synchroniser; the output moves once stages two and three agree.
module cbdiag_sync (
  input wire logic i_clk,   // System clock.
  input wire logic i_rstn,  // Global reset, active low.
  input wire logic i_async, // Level from outside the clock domain.
  output logic o_level      // Filtered, synchronised level.
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        o_level <= s3;
      end
    end
  end
endmodule

/* File: hw/cbdiag_field_reg.sv */
`timescale 1ns/1ps

// Byte register in which only the bits set in MASK can be written.
module cbdiag_field_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST = '0,
  parameter logic [WIDTH-1:0] MASK = '1
) (
  input wire logic i_clk,              // System clock.
  input wire logic i_rstn,             // Global reset, active low.
  input wire logic i_we,               // Write strobe.
  input wire logic [WIDTH-1:0] i_wdata, // Write data.
  output logic [WIDTH-1:0] o_q         // Stored value.
);
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_q <= RST;
    end
    else if (i_we)
    begin
      o_q <= (o_q & ~MASK) | (i_wdata & MASK);
    end
  end
endmodule

/* File: hw/cbdiag_regs.sv */
// Contract
// RQ1: Device control byte sits at 92h in both functions, reset value 66h.
// RQ2: Power lock set blocks socket power-down requests while the function is in D3.
// RQ3: Bit 6 forces reported 3-V capability; reset reports capable.
// RQ4: Bit 5 is a read/write diagnostic bit resetting to one.
// RQ5: Bit 4 reads zero and ignores writes.
// RQ6: Test bit should stay zero; when set it shortens interrogation counting.
// RQ7: Bits 2-1 select the interrupt signalling scheme, default serial IRQ and PCI.
// RQ8: Bit 0 enables the NAND-tree chain over input and bidirectional pins.
// RQ9: Global bits are one shared copy, written only through function 0.
// RQ10: Only the global reset restores these bits; bus reset leaves them.
// RQ11: Diagnostic byte sits at 93h in both functions.
// RQ12: Diagnostic bit 7 makes vendor and device ID reads return all ones.
// RQ13: Diagnostic bit 5 chooses which compatibility bits route status-change interrupts.
// RQ14: Diagnostic bit 4 disables delayed transactions.
// RQ15: Diagnostic bit 3 extends retry latency limit from 16 to 64 clocks.
// RQ16: Diagnostic bit 2 picks card-side discard timer 2^10 or 2^15.
// RQ17: Diagnostic bit 1 picks host-side discard timer 2^10 or 2^15.
// RQ18: Diagnostic bit 0 enables asynchronous status-change interrupt generation.
// RQ19: Reserved read/write bits store and return data with no side effect.
`timescale 1ns/1ps
`include "cbdiag_params.svh"

module cbdiag_regs #(
  parameter int NUM_FUNC = `CBDIAG_NUM_FUNC
) (
  input wire logic i_clk,                            // 40 MHz clock.
  input wire logic i_rstn,                           // Global reset, active low.
  input wire logic i_pci_rstn,                       // Bus reset pin, active low.
  input wire cbdiag_pkg::cbdiag_cfg_req_t i_cfg_req, // Configuration access.
  output cbdiag_pkg::cbdiag_cfg_rsp_t o_cfg_rsp,     // Access answer.
  input wire logic [31:0] i_id_value,                // True device and vendor ID.
  input wire logic [NUM_FUNC-1:0] i_in_d3,           // Function is in D3.
  input wire logic [NUM_FUNC-1:0] i_pwr_down_req,    // Software power-down pulse.
  input wire logic [NUM_FUNC-1:0] i_compat_803_b4,   // Compatibility 803 bit 4.
  input wire logic [3:0] i_compat_805_hi0,           // Compatibility 805 bits 7-4, f0.
  input wire logic [3:0] i_compat_805_hi1,           // Compatibility 805 bits 7-4, f1.
  output logic [NUM_FUNC-1:0] o_sock_pwr_down,       // Accepted power-down pulse.
  output logic o_three_volt_capable,                 // Reported 3-V capability.
  output logic [NUM_FUNC-1:0] o_legacy_diagnostic_field_bit,     // Diagnostic bit per function.
  output logic o_interrog_short,                     // Shortened interrogation.
  output cbdiag_pkg::cbdiag_irq_mode_t o_irq_signal_mode, // Interrupt scheme.
  output logic o_nand_tree_en,                       // NAND-tree chain enable.
  output logic [NUM_FUNC-1:0] o_csc_route_pci,       // Status change to PCI.
  output logic o_delayed_txn_disable,                // Delayed transactions off.
  output logic [6:0] o_retry_limit,                  // Retry latency in clocks.
  output logic [4:0] o_card_discard_log2,            // Card-side discard log2.
  output logic [4:0] o_host_discard_log2,            // Host-side discard log2.
  output logic o_async_status_change_irq             // Asynchronous generation.
);
  import cbdiag_pkg::*;

  logic pci_rst_active_n;
  logic [7:0] dev_glob_q;
  logic [7:0] diagnostic_field_glob_q;
  logic [7:0] dev_loc_q [NUM_FUNC];
  logic [7:0] diagnostic_field_loc_q [NUM_FUNC];
  cbdiag_dev_ctrl_t dev_view [NUM_FUNC];
  cbdiag_diagnostic_field_t diagnostic_field_view [NUM_FUNC];
  cbdiag_dev_ctrl_t dev_f0;
  cbdiag_diagnostic_field_t diagnostic_field_f0;

  // Bus reset must not disturb the stored bits, so it only blocks accesses and quiets the power-down pulse.
  cbdiag_sync u_pci_rst_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(i_pci_rstn),
    .o_level(pci_rst_active_n)
  );

  wire access = i_cfg_req.valid & pci_rst_active_n;
  wire hit_dev = i_cfg_req.offset == `CBDIAG_OFS_DEV_CTRL; // RQ1
  wire hit_diagnostic_field = i_cfg_req.offset == `CBDIAG_OFS_DIAGNOSTIC_FIELD; // RQ11
  wire hit_id = i_cfg_req.offset <= `CBDIAG_OFS_ID_LAST;
  wire wr_dev = access & i_cfg_req.write & hit_dev;
  wire wr_diagnostic_field = access & i_cfg_req.write & hit_diagnostic_field;
  // Function 1 writes to shared bits are dropped so it cannot override function 0.
  wire wr_dev_glob = wr_dev & ~i_cfg_req.func; // RQ9
  wire wr_diagnostic_field_glob = wr_diagnostic_field & ~i_cfg_req.func; // RQ9

  // Only i_rstn, the global reset, loads these registers with their reset values.
  cbdiag_field_reg #(
    .WIDTH(8),
    .RST(`CBDIAG_DEV_CTRL_RST),
    .MASK(`CBDIAG_DEV_GLOBAL_MASK)
  ) u_dev_glob (
    .i_clk(i_clk),
    .i_rstn(i_rstn), // RQ10
    .i_we(wr_dev_glob),
    .i_wdata(i_cfg_req.wdata),
    .o_q(dev_glob_q)
  );

  cbdiag_field_reg #(
    .WIDTH(8),
    .RST(`CBDIAG_DIAGNOSTIC_FIELD_RST),
    .MASK(`CBDIAG_DIAGNOSTIC_FIELD_GLOBAL_MASK)
  ) u_diagnostic_field_glob (
    .i_clk(i_clk),
    .i_rstn(i_rstn), // RQ10
    .i_we(wr_diagnostic_field_glob),
    .i_wdata(i_cfg_req.wdata),
    .o_q(diagnostic_field_glob_q)
  );

  for (genvar f = 0; f < NUM_FUNC; f++)
  begin : g_func
    wire sel = i_cfg_req.func == 1'(f);

    cbdiag_field_reg #(
      .WIDTH(8),
      .RST(`CBDIAG_DEV_CTRL_RST),
      .MASK(`CBDIAG_DEV_LOCAL_MASK)
    ) u_dev_loc (
      .i_clk(i_clk),
      .i_rstn(i_rstn), // RQ10
      .i_we(wr_dev & sel), // RQ4
      .i_wdata(i_cfg_req.wdata),
      .o_q(dev_loc_q[f])
    );

    cbdiag_field_reg #(
      .WIDTH(8),
      .RST(`CBDIAG_DIAGNOSTIC_FIELD_RST),
      .MASK(`CBDIAG_DIAGNOSTIC_FIELD_LOCAL_MASK)
    ) u_diagnostic_field_loc (
      .i_clk(i_clk),
      .i_rstn(i_rstn), // RQ10
      .i_we(wr_diagnostic_field & sel), // RQ19
      .i_wdata(i_cfg_req.wdata),
      .o_q(diagnostic_field_loc_q[f])
    );

    // Bit 4 is in neither mask, so it stays at its reset zero.
    assign dev_view[f] = (dev_glob_q & `CBDIAG_DEV_GLOBAL_MASK)
                       | (dev_loc_q[f] & `CBDIAG_DEV_LOCAL_MASK); // RQ5
    assign diagnostic_field_view[f] = (diagnostic_field_glob_q & `CBDIAG_DIAGNOSTIC_FIELD_GLOBAL_MASK)
                        | (diagnostic_field_loc_q[f] & `CBDIAG_DIAGNOSTIC_FIELD_LOCAL_MASK);
  end

  assign dev_f0 = dev_view[0];
  assign diagnostic_field_f0 = diagnostic_field_view[0];

  // Read selection for the addressed function.
  wire [1:0] id_byte = i_cfg_req.offset[1:0];
  wire [7:0] id_true = i_id_value[8*id_byte +: 8];
  wire id_masked = diagnostic_field_view[i_cfg_req.func].id_mask;
  wire [7:0] id_rdata = id_masked ? `CBDIAG_ID_ALL_ONES : id_true; // RQ12
  wire [7:0] dev_rdata = dev_view[i_cfg_req.func]; // RQ5
  wire [7:0] diagnostic_field_rdata = diagnostic_field_view[i_cfg_req.func]; // RQ19
  wire [7:0] next_rdata = hit_dev ? dev_rdata
                        : hit_diagnostic_field ? diagnostic_field_rdata
                        : hit_id ? id_rdata
                        : `CBDIAG_RDATA_NONE;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_cfg_rsp <= '0;
    end
    else
    begin
      o_cfg_rsp.ack <= access;
      if (access && !i_cfg_req.write)
      begin
        o_cfg_rsp.rdata <= next_rdata;
      end
    end
  end

  // Power-down requests and status-change routing, one set per function.
  logic [NUM_FUNC-1:0] next_pwr_down;
  logic [NUM_FUNC-1:0] next_csc_route;
  logic [3:0] compat_805_hi [NUM_FUNC];

  assign compat_805_hi[0] = i_compat_805_hi0;
  assign compat_805_hi[1] = i_compat_805_hi1;

  for (genvar f = 0; f < NUM_FUNC; f++)
  begin : g_side
    wire locked = dev_view[f].pwr_lock & i_in_d3[f];
    wire route_805 = compat_805_hi[f] == 4'h0;
    assign next_pwr_down[f] = i_pwr_down_req[f] & ~locked; // RQ2
    assign next_csc_route[f] = diagnostic_field_view[f].csc_route_sel ? route_805
                             : i_compat_803_b4[f]; // RQ13
  end

  // Timer and limit selections derived from the shared diagnostic bits.
  wire [6:0] next_retry_limit = diagnostic_field_f0.retry_latency_extend
                              ? `CBDIAG_RETRY_LIMIT_EXT
                              : `CBDIAG_RETRY_LIMIT_BASE; // RQ15
  wire [4:0] next_card_log2 = diagnostic_field_f0.card_discard_timer_sel
                            ? 5'(`CBDIAG_DISCARD_LOG2_SHORT)
                            : 5'(`CBDIAG_DISCARD_LOG2_LONG); // RQ16
  wire [4:0] next_host_log2 = diagnostic_field_f0.host_discard_timer_sel
                            ? 5'(`CBDIAG_DISCARD_LOG2_SHORT)
                            : 5'(`CBDIAG_DISCARD_LOG2_LONG); // RQ17
  wire [NUM_FUNC-1:0] next_legacy = {dev_view[1].legacy_diagnostic_field_bit,
                                     dev_view[0].legacy_diagnostic_field_bit}; // RQ4

  // Control outputs follow the stored bits with one clock of delay.
  // One short process per output keeps each reset value beside the bit that feeds it.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_three_volt_capable <= 1'b1;
    end
    else
    begin
      o_three_volt_capable <= dev_f0.three_volt_capable_force; // RQ3
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_legacy_diagnostic_field_bit <= '1;
    end
    else
    begin
      o_legacy_diagnostic_field_bit <= next_legacy;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_interrog_short <= 1'b0;
    end
    else
    begin
      o_interrog_short <= dev_f0.test_shorten; // RQ6
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_irq_signal_mode <= CBDIAG_IRQ_SER_IRQ_SER_PCI;
    end
    else
    begin
      o_irq_signal_mode <= dev_f0.irq_signal_mode; // RQ7
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_nand_tree_en <= 1'b0;
    end
    else
    begin
      o_nand_tree_en <= dev_f0.nand_tree_en; // RQ8
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_delayed_txn_disable <= 1'b0;
    end
    else
    begin
      o_delayed_txn_disable <= diagnostic_field_f0.delayed_txn_disable; // RQ14
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_retry_limit <= `CBDIAG_RETRY_LIMIT_BASE;
    end
    else
    begin
      o_retry_limit <= next_retry_limit;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_card_discard_log2 <= 5'(`CBDIAG_DISCARD_LOG2_LONG);
    end
    else
    begin
      o_card_discard_log2 <= next_card_log2;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_host_discard_log2 <= 5'(`CBDIAG_DISCARD_LOG2_LONG);
    end
    else
    begin
      o_host_discard_log2 <= next_host_log2;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_async_status_change_irq <= 1'b1;
    end
    else
    begin
      o_async_status_change_irq <= diagnostic_field_f0.async_status_change_irq; // RQ18
    end
  end

  // The per-function power-down pulse is quieted while bus reset is held; status-change routing is not.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_sock_pwr_down <= '0;
      o_csc_route_pci <= '0;
    end
    else
    begin
      o_sock_pwr_down <= next_pwr_down & {NUM_FUNC{pci_rst_active_n}};
      o_csc_route_pci <= next_csc_route;
    end
  end

endmodule

/* File: test/cbdiag_regs_sva.sv */
`timescale 1ns/1ps
module cbdiag_regs_chk #(
  parameter int NUM_FUNC = 2
) (
  input wire logic i_clk, // Clock.
  input wire logic i_rstn, // Global reset.
  input wire logic i_pci_rstn, // Bus reset.
  input wire cbdiag_pkg::cbdiag_cfg_req_t i_cfg_req, // Request.
  input wire cbdiag_pkg::cbdiag_cfg_rsp_t o_cfg_rsp, // Answer.
  input wire logic [NUM_FUNC-1:0] i_in_d3, // D3 state.
  input wire logic [NUM_FUNC-1:0] i_pwr_down_req, // Power-down request.
  input wire logic [NUM_FUNC-1:0] o_sock_pwr_down, // Power-down pulse.
  input wire logic o_three_volt_capable, // 3-V report.
  input wire cbdiag_pkg::cbdiag_irq_mode_t o_irq_signal_mode, // Scheme.
  input wire logic o_nand_tree_en, // Chain enable.
  input wire logic o_delayed_txn_disable, // Delayed off.
  input wire logic [6:0] o_retry_limit, // Retry limit.
  input wire logic [4:0] o_card_discard_log2, // Card timer.
  input wire logic [4:0] o_host_discard_log2, // Host timer.
  input wire logic o_async_status_change_irq // Async generation.
);
  import cbdiag_pkg::*;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Requests count only once the bus reset synchroniser has surely settled high.
  logic [2:0] up_cnt;
  logic [7:0] wd1, wd2;
  logic live, wr_dev, wr_diagnostic_field;
  assign live = i_cfg_req.valid && (up_cnt >= 3'd6);
  assign wr_dev = live && i_cfg_req.write && !i_cfg_req.func && (i_cfg_req.offset == 8'h92);
  assign wr_diagnostic_field = live && i_cfg_req.write && !i_cfg_req.func && (i_cfg_req.offset == 8'h93);
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      up_cnt <= '0;
    else if (!i_pci_rstn)
      up_cnt <= '0;
    else if (up_cnt != 3'd7)
      up_cnt <= up_cnt + 3'd1;
  end
  always_ff @(posedge i_clk)
  begin
    wd1 <= i_cfg_req.wdata;
    wd2 <= wd1;
  end
  ack_cause_a: assert property (o_cfg_rsp.ack |-> $past(i_cfg_req.valid))
    else $error("ack without request");
  dev_fields_a: assert property (wr_dev |-> ##2 (o_irq_signal_mode == wd2[2:1]
    && o_three_volt_capable == wd2[6] && o_nand_tree_en == wd2[0])) else $error("dev fields");
  retry_len_a: assert property (wr_diagnostic_field |-> ##2 o_retry_limit == (wd2[3] ? 7'd64 : 7'd16))
    else $error("retry limit");
  timers_a: assert property (wr_diagnostic_field |-> ##2
    (o_card_discard_log2 == (wd2[2] ? 5'd10 : 5'd15)
    && o_host_discard_log2 == (wd2[1] ? 5'd10 : 5'd15))) else $error("discard timers");
  diagnostic_field_flags_a: assert property (wr_diagnostic_field |-> ##2 (o_delayed_txn_disable == wd2[4]
    && o_async_status_change_irq == wd2[0])) else $error("diagnostic_field flags");
  pwr_pass_a: assert property (i_pwr_down_req[0] && !i_in_d3[0] && up_cnt >= 3'd6
    |=> o_sock_pwr_down[0]) else $error("power-down lost");
  f1_global_a: assert property (live && i_cfg_req.write && i_cfg_req.func
    && i_cfg_req.offset == 8'h93 |-> ##2 $stable(o_retry_limit)) else $error("f1 global write");
  reset_vals_a: assert property ($rose(i_rstn) |-> o_retry_limit == 7'd16
    && o_irq_signal_mode == CBDIAG_IRQ_SER_IRQ_SER_PCI && o_async_status_change_irq)
    else $error("reset values");
  cover property (wr_diagnostic_field);
  cover property (o_sock_pwr_down[0]);
  cover property (live && !i_cfg_req.write && i_cfg_req.offset == 8'h00);
endmodule

bind cbdiag_regs cbdiag_regs_chk #(.NUM_FUNC(NUM_FUNC)) u_chk (
  .i_clk, .i_rstn, .i_pci_rstn, .i_cfg_req, .o_cfg_rsp, .i_in_d3, .i_pwr_down_req,
  .o_sock_pwr_down, .o_three_volt_capable, .o_irq_signal_mode, .o_nand_tree_en,
  .o_delayed_txn_disable, .o_retry_limit, .o_card_discard_log2, .o_host_discard_log2,
  .o_async_status_change_irq
);

/* File: test/cbdiag_host.sv */
`timescale 1ns/1ps
module cbdiag_host (
  input wire logic i_clk, // Clock.
  input wire cbdiag_pkg::cbdiag_cfg_rsp_t i_rsp, // Answer.
  output cbdiag_pkg::cbdiag_cfg_req_t o_req // Request.
);
  import cbdiag_pkg::*;
  initial o_req = '0;
  // Entered just after an edge; idle fields flip so stale values never look live.
  task automatic xfer(input logic w, input logic f, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic ok);
    o_req = '{1'b1, w, f, a, d};
    @(posedge i_clk);
    #1;
    ok = i_rsp.ack;
    rd = i_rsp.rdata;
    o_req = '{1'b0, 1'b0, ~f, ~a, ~d};
    @(posedge i_clk);
    #1;
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import cbdiag_pkg::*;
  logic i_clk, i_rstn, i_pci_rstn;
  logic [1:0] i_in_d3, i_pwr_down_req, i_compat_803_b4, o_sock_pwr_down, o_legacy_diagnostic_field_bit;
  logic [1:0] o_csc_route_pci;
  logic [3:0] i_compat_805_hi0, i_compat_805_hi1;
  logic [31:0] i_id_value;
  cbdiag_cfg_req_t i_cfg_req;
  cbdiag_cfg_rsp_t o_cfg_rsp;
  cbdiag_irq_mode_t o_irq_signal_mode;
  logic o_three_volt_capable, o_interrog_short, o_nand_tree_en, o_delayed_txn_disable;
  logic o_async_status_change_irq;
  logic [6:0] o_retry_limit;
  logic [4:0] o_card_discard_log2, o_host_discard_log2;
  logic [7:0] rd;
  logic ok;
  int errors;
  int checks_done;
  // Arbitrary identification value.
  assign i_id_value = 32'h1234_5678;
  cbdiag_regs #(.NUM_FUNC(2)) dut (
    .i_clk, .i_rstn, .i_pci_rstn, .i_cfg_req, .o_cfg_rsp, .i_id_value, .i_in_d3,
    .i_pwr_down_req, .i_compat_803_b4, .i_compat_805_hi0, .i_compat_805_hi1,
    .o_sock_pwr_down, .o_three_volt_capable, .o_legacy_diagnostic_field_bit, .o_interrog_short,
    .o_irq_signal_mode, .o_nand_tree_en, .o_csc_route_pci, .o_delayed_txn_disable,
    .o_retry_limit, .o_card_discard_log2, .o_host_discard_log2, .o_async_status_change_irq
  );
  cbdiag_host host (.i_clk(i_clk), .i_rsp(o_cfg_rsp), .o_req(i_cfg_req));
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic f, input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, f, a, d, rd, ok);
    chk("write ack", {7'd0, ok}, 8'h01);
  endtask
  task automatic rdc(input string n, input logic f, input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, f, a, 8'h00, rd, ok);
    chk(n, rd, e);
  endtask
  task automatic chk_dev(input logic [7:0] e);
    chk("dev outputs", {o_three_volt_capable, o_legacy_diagnostic_field_bit, o_interrog_short,
        o_nand_tree_en, o_irq_signal_mode, 1'b0}, e);
  endtask
  task automatic chk_diagnostic_field(input logic [7:0] r, input logic [7:0] t, input logic [7:0] f);
    chk("retry", {1'b0, o_retry_limit}, r);
    chk("timers", {o_card_discard_log2[3:0], o_host_discard_log2[3:0]}, t);
    chk("flags", {6'd0, o_delayed_txn_disable, o_async_status_change_irq}, f);
  endtask
  task automatic t_reset;
    rdc("dev f0", 1'b0, 8'h92, 8'h66);
    rdc("dev f1", 1'b1, 8'h92, 8'h66);
    rdc("diagnostic_field f0", 1'b0, 8'h93, 8'h61);
    rdc("diagnostic_field f1", 1'b1, 8'h93, 8'h61);
    chk_dev(8'hE6);
    chk_diagnostic_field(8'h10, 8'hFF, 8'h01);
  endtask
  task automatic t_devctl;
    wr(1'b0, 8'h92, 8'hFF);
    rdc("dev zero bit", 1'b0, 8'h92, 8'hEF);
    rdc("dev shared", 1'b1, 8'h92, 8'h6F);
    chk_dev(8'hFE);
    wr(1'b1, 8'h92, 8'h00);
    rdc("dev f1 write", 1'b1, 8'h92, 8'h4F);
    chk_dev(8'hBE);
    for (int m = 0; m < 4; m++)
    begin
      wr(1'b0, 8'h92, {5'd0, 2'(m), 1'b0});
      chk("irq mode", {6'd0, o_irq_signal_mode}, 8'(m));
    end
    chk("3v cap", {7'd0, o_three_volt_capable}, 8'h00);
  endtask
  task automatic t_diagnostic_field;
    wr(1'b0, 8'h93, 8'h9F);
    chk_diagnostic_field(8'h40, 8'hAA, 8'h03);
    rdc("id masked", 1'b0, 8'h00, 8'hFF);
    rdc("id masked f1", 1'b1, 8'h03, 8'hFF);
    wr(1'b1, 8'h93, 8'h40);
    rdc("diagnostic_field f1", 1'b1, 8'h93, 8'hDF);
    wr(1'b0, 8'h93, 8'h00);
    chk_diagnostic_field(8'h10, 8'hFF, 8'h00);
    rdc("id true", 1'b0, 8'h01, 8'h56);
    rdc("unmapped", 1'b0, 8'h50, 8'h00);
  endtask
  task automatic t_route;
    i_compat_803_b4 = 2'b11;
    i_compat_805_hi0 = 4'hF;
    tick(2);
    chk("route 803", {6'd0, o_csc_route_pci}, 8'h03);
    wr(1'b0, 8'h93, 8'h20);
    tick(1);
    chk("route 805 busy", {6'd0, o_csc_route_pci}, 8'h02);
    i_compat_805_hi0 = 4'h0;
    tick(2);
    chk("route 805 clear", {6'd0, o_csc_route_pci}, 8'h03);
  endtask
  task automatic t_power;
    wr(1'b0, 8'h92, 8'h80);
    i_in_d3 = 2'b11;
    i_pwr_down_req = 2'b11;
    tick(1);
    chk("pwr locked", {6'd0, o_sock_pwr_down}, 8'h02);
    i_in_d3 = 2'b00;
    i_pwr_down_req = 2'b01;
    tick(1);
    chk("pwr free", {6'd0, o_sock_pwr_down}, 8'h01);
    i_pwr_down_req = 2'b00;
    tick(1);
  endtask
  task automatic t_busrst;
    i_pci_rstn = 1'b0;
    tick(5);
    host.xfer(1'b0, 1'b0, 8'h92, 8'h00, rd, ok);
    chk("bus reset ack", {7'd0, ok}, 8'h00);
    i_pci_rstn = 1'b1;
    tick(6);
    rdc("after bus reset", 1'b0, 8'h92, 8'h80);
    i_rstn = 1'b0;
    tick(2);
    i_rstn = 1'b1;
    tick(6);
    rdc("global dev", 1'b0, 8'h92, 8'h66);
    rdc("global diagnostic_field", 1'b0, 8'h93, 8'h61);
  endtask
  initial
  begin
    {i_rstn, i_in_d3, i_pwr_down_req, i_compat_803_b4, i_compat_805_hi0} = '0;
    i_compat_805_hi1 = 4'h0;
    i_pci_rstn = 1'b1;
    repeat (10) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    tick(6);
    t_reset();
    t_devctl();
    t_diagnostic_field();
    t_route();
    t_power();
    t_busrst();
    give_verdict();
  end
  // Whole run needs about a hundred clocks; this margin only catches a hang.
  initial
  begin
    #(2000 * 25);
    errors++;
    give_verdict();
  end
endmodule
